// [ppac_pkg.sv]
// Purpose: Shared constants for the parallel port block with converter-shared pins.
// Assumes: Four banks (B, D, E, F) of up to 16 pins, 32-bit Avalon-MM register bus.
// Notes:   Bank index 0..3 maps to B, D, E, F.
package ppac_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int NUM_BANKS = 4;
    localparam int PORT_W = 16;
    localparam int BUS_W = 32;
    localparam int ADDR_W = 8;
    localparam int SYNC_STAGES = 3;

    localparam logic [1:0] BANK_B = 2'h0;
    localparam logic [1:0] BANK_D = 2'h1;
    localparam logic [1:0] BANK_E = 2'h2;
    localparam logic [1:0] BANK_F = 2'h3;

    // ----------------------------------------------------------------
    // Register map: byte address = bank * 0x10 + register * 0x4
    // ----------------------------------------------------------------
    localparam int BANK_LSB = 4;
    localparam int REG_LSB = 2;
    localparam logic [ADDR_W-1:0] BANK_STRIDE = 8'h10;
    localparam logic [1:0] REG_DIRECTION = 2'h0;
    localparam logic [1:0] REG_PIN_VALUE = 2'h1;
    localparam logic [1:0] REG_OUTPUT_LATCH = 2'h2;

    localparam logic [ADDR_W-1:0] DIRECTION_BANK_B_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] PIN_VALUE_BANK_B_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] OUTPUT_LATCH_BANK_B_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] DIRECTION_BANK_D_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] PIN_VALUE_BANK_D_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] OUTPUT_LATCH_BANK_D_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] DIRECTION_BANK_E_OFS = 8'h20;
    localparam logic [ADDR_W-1:0] PIN_VALUE_BANK_E_OFS = 8'h24;
    localparam logic [ADDR_W-1:0] OUTPUT_LATCH_BANK_E_OFS = 8'h28;
    localparam logic [ADDR_W-1:0] DIRECTION_BANK_F_OFS = 8'h30;
    localparam logic [ADDR_W-1:0] PIN_VALUE_BANK_F_OFS = 8'h34;
    localparam logic [ADDR_W-1:0] OUTPUT_LATCH_BANK_F_OFS = 8'h38;

    // ----------------------------------------------------------------
    // Implemented bits and reset values
    // ----------------------------------------------------------------
    localparam logic [NUM_BANKS-1:0][PORT_W-1:0] IMPL_MASK = {
        16'h007f,   // F
        16'h013f,   // E
        16'h000f,   // D
        16'h01ff    // B
    };
    localparam logic [NUM_BANKS-1:0][PORT_W-1:0] DIRECTION_RESET = IMPL_MASK;
    localparam logic [PORT_W-1:0] LATCH_RESET = 16'h0000;
    localparam logic [PORT_W-1:0] PIN_VALUE_RESET = 16'h0000;
    localparam logic [BUS_W-1:0] READ_ZERO = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Bus handshake states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } ppac_bus_state_t;

endpackage

// [ppac_sync.sv]
// Purpose: Three-flop input synchroniser with agreement filter, one per bit.
// Assumes: Inputs are asynchronous to clock.
// Notes:   Output changes only when the second and third stages agree.
`timescale 1ns/10ps
`default_nettype none
module ppac_sync #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import ppac_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] agreed;
    } ppac_sync_state_t;

    ppac_sync_state_t state_reg;
    ppac_sync_state_t state_next;

    // ----------------------------------------------------------------
    // Stage shift; first stage feeds only the second
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.s1 = async_in;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (state_reg.s2[i] == state_reg.s3[i]) begin
                state_next.agreed[i] = state_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= '{s1: RESET_VALUE, s2: RESET_VALUE, s3: RESET_VALUE, agreed: RESET_VALUE};
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.agreed;

endmodule
`default_nettype wire

// [ppac_top.sv]
// Purpose: Parallel port banks B, D, E, F with converter-shared pins, Avalon-MM slave.
// Assumes: 100 MHz clock, asynchronous active-high reset, pins asynchronous to clock.
// Notes:   Pin output enables are active low; analog select comes from the converter.
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ppac_top (
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [ppac_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ppac_pkg::BUS_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [ppac_pkg::BUS_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Pins, one 16-bit lane per bank
    input wire logic [ppac_pkg::NUM_BANKS-1:0][ppac_pkg::PORT_W-1:0] pin_in,
    output logic [ppac_pkg::NUM_BANKS-1:0][ppac_pkg::PORT_W-1:0] pin_out,
    output logic [ppac_pkg::NUM_BANKS-1:0][ppac_pkg::PORT_W-1:0] pin_oe_n,
    // Converter side, bank B pins are the analog_input_pin set
    input wire logic [ppac_pkg::PORT_W-1:0] analog_pin_select,
    output logic [ppac_pkg::PORT_W-1:0] converter_connect,
    output logic [ppac_pkg::PORT_W-1:0] converter_digital_mode,
    output logic [ppac_pkg::PORT_W-1:0] converter_digital_level
);
    import ppac_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        ppac_bus_state_t bus;
        logic waitreq;
        logic [BUS_W-1:0] rdata;
        logic [NUM_BANKS-1:0][PORT_W-1:0] direction;
        logic [NUM_BANKS-1:0][PORT_W-1:0] latch;
        logic [NUM_BANKS-1:0][PORT_W-1:0] pin_value;
        logic [NUM_BANKS-1:0][PORT_W-1:0] drive;
        logic [NUM_BANKS-1:0][PORT_W-1:0] enable_n;
        logic [PORT_W-1:0] conv_connect;
        logic [PORT_W-1:0] conv_digital;
        logic [PORT_W-1:0] conv_level;
    } ppac_state_t;

    localparam ppac_state_t STATE_RESET = '{
        bus: BUS_IDLE,
        waitreq: 1'b1,
        rdata: READ_ZERO,
        direction: DIRECTION_RESET,
        latch: {NUM_BANKS{LATCH_RESET}},
        pin_value: {NUM_BANKS{PIN_VALUE_RESET}},
        drive: {NUM_BANKS{LATCH_RESET}},
        enable_n: DIRECTION_RESET | ~IMPL_MASK,
        conv_connect: 16'h0000,
        conv_digital: 16'h0000,
        conv_level: 16'h0000
    };

    ppac_state_t state_reg;
    ppac_state_t state_next;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [NUM_BANKS-1:0][PORT_W-1:0] pin_sync;

    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : g_bank_sync
            ppac_sync #(
                .WIDTH(PORT_W),
                .RESET_VALUE(PIN_VALUE_RESET)
            ) u_sync (
                .clock(clock),
                .rst(rst),
                .async_in(pin_in[g]),
                .sync_out(pin_sync[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic [1:0] sel_bank;
    logic [1:0] sel_reg;
    logic sel_mapped;
    logic [PORT_W-1:0] wr_mask;
    logic [PORT_W-1:0] wr_data;

    assign sel_bank = avs_address[BANK_LSB +: 2];
    assign sel_reg = avs_address[REG_LSB +: 2];
    // Top address bits beyond the four banks and register slot 3 are unmapped
    assign sel_mapped = (avs_address[ADDR_W-1:BANK_LSB+2] == '0) && (sel_reg != 2'h3);
    // Only the low two byte lanes carry register bits
    assign wr_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wr_data = avs_writedata[PORT_W-1:0];

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [PORT_W-1:0] mask;
        logic [PORT_W-1:0] rd_word;
        logic [PORT_W-1:0] analog_gate;
        logic [NUM_BANKS-1:0][PORT_W-1:0] dir_n;
        logic [NUM_BANKS-1:0][PORT_W-1:0] lat_n;
        mask = IMPL_MASK[sel_bank];
        rd_word = 16'h0000;
        analog_gate = 16'h0000;
        dir_n = state_reg.direction;
        lat_n = state_reg.latch;
        state_next = state_reg;

        // Digital input path; analog-selected bank B pins are gated off
        for (int b = 0; b < NUM_BANKS; b++) begin
            analog_gate = (b == int'(BANK_B)) ? analog_pin_select : 16'h0000;
            state_next.pin_value[b] = pin_sync[b] & ~analog_gate & IMPL_MASK[b];
        end

        // Bus handshake: one wait cycle, then a single acknowledge cycle
        unique case (state_reg.bus)
            BUS_IDLE: begin
                state_next.waitreq = 1'b1;
                if (avs_read || avs_write) begin
                    state_next.bus = BUS_ACK;
                    state_next.waitreq = 1'b0;
                    if (avs_read && sel_mapped) begin
                        unique case (sel_reg)
                            REG_DIRECTION: rd_word = state_reg.direction[sel_bank];
                            REG_OUTPUT_LATCH: rd_word = state_reg.latch[sel_bank];
                            default: rd_word = state_reg.pin_value[sel_bank];
                        endcase
                    end
                    state_next.rdata = {16'h0000, rd_word & mask};
                end else begin
                    state_next.rdata = READ_ZERO;
                end
            end
            BUS_ACK: begin
                state_next.bus = BUS_IDLE;
                state_next.waitreq = 1'b1;
                state_next.rdata = READ_ZERO;
                // Write commits on the edge where the master sees waitrequest low
                if (avs_write && sel_mapped) begin
                    if (sel_reg == REG_DIRECTION) begin
                        state_next.direction[sel_bank] = (state_reg.direction[sel_bank] & ~(wr_mask & mask))
                            | (wr_data & wr_mask & mask);
                    end else begin
                        // Pin-value and latch writes both land in the latch
                        state_next.latch[sel_bank] = (state_reg.latch[sel_bank] & ~(wr_mask & mask))
                            | (wr_data & wr_mask & mask);
                    end
                end
            end
            default: begin
                state_next.bus = BUS_IDLE;
                state_next.waitreq = 1'b1;
                state_next.rdata = READ_ZERO;
            end
        endcase

        // Pad drive follows the values the registers take at this edge
        dir_n = state_next.direction;
        lat_n = state_next.latch;
        for (int b = 0; b < NUM_BANKS; b++) begin
            state_next.drive[b] = lat_n[b] & ~dir_n[b] & IMPL_MASK[b];
            state_next.enable_n[b] = dir_n[b] | ~IMPL_MASK[b];
        end

        // Converter view of bank B; a digital input pin never reaches it
        state_next.conv_connect = analog_pin_select & IMPL_MASK[BANK_B];
        // An analog pin left as output converts its own driven level, so software keeps it input
        state_next.conv_digital = analog_pin_select & ~dir_n[BANK_B] & IMPL_MASK[BANK_B];
        state_next.conv_level = lat_n[BANK_B] & state_next.conv_digital;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign avs_readdata = state_reg.rdata;
    assign avs_waitrequest = state_reg.waitreq;
    assign pin_out = state_reg.drive;
    assign pin_oe_n = state_reg.enable_n;
    assign converter_connect = state_reg.conv_connect;
    assign converter_digital_mode = state_reg.conv_digital;
    assign converter_digital_level = state_reg.conv_level;

endmodule
`default_nettype wire

// [ppac_props.sv]
// Purpose: Port-level checks for the parallel port block.
// Assumes: One clock domain, rst active high.
// Notes:   Sees only the top module ports.
`timescale 1ns/10ps
`default_nettype none
module ppac_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ppac_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ppac_pkg::BUS_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [ppac_pkg::NUM_BANKS-1:0][ppac_pkg::PORT_W-1:0] pin_out,
    input wire logic [ppac_pkg::NUM_BANKS-1:0][ppac_pkg::PORT_W-1:0] pin_oe_n,
    input wire logic [ppac_pkg::PORT_W-1:0] analog_pin_select,
    input wire logic [ppac_pkg::PORT_W-1:0] converter_connect,
    input wire logic [ppac_pkg::PORT_W-1:0] converter_digital_mode,
    input wire logic [ppac_pkg::PORT_W-1:0] converter_digital_level
);
    import ppac_pkg::*;
    // ----------------------------------------------------------------
    // Sequences and properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_bus_ack_once: assert property (s_take |=> s_ack)
        else $error("request not acked for exactly one cycle");
    a_idle_read_zero: assert property (avs_waitrequest |-> avs_readdata == READ_ZERO)
        else $error("read data not zero outside ack");
    a_upper_half_zero: assert property (avs_readdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    // Reset is the antecedent here, so this one is never disabled
    a_reset_pins: assert property (disable iff (1'b0) rst |-> pin_out == '0 && pin_oe_n == '1)
        else $error("pins not released during reset");
    a_oe_unimpl: assert property ((pin_oe_n | IMPL_MASK) == '1)
        else $error("unimplemented pin enabled");
    a_drive_gated: assert property ((pin_out & (pin_oe_n | ~IMPL_MASK)) == '0)
        else $error("pin level shown while not driving");
    a_conn_follows: assert property (!$past(rst) |->
        converter_connect == ($past(analog_pin_select) & IMPL_MASK[0]))
        else $error("converter routing does not follow select");
    a_dig_mode: assert property (converter_digital_mode == (converter_connect & ~pin_oe_n[0]))
        else $error("converter mode wrong for output pin");
    a_dig_level: assert property (converter_digital_level == (converter_digital_mode & pin_out[0]))
        else $error("converter level differs from drive");
    a_analog_reads_zero: assert property (!avs_waitrequest && avs_read
        && avs_address == PIN_VALUE_BANK_B_OFS |-> (avs_readdata[15:0] & converter_connect) == 16'h0000)
        else $error("analog pin read not zero");
endmodule
`default_nettype wire

// [ppac_board.sv]
// Purpose: Board model at the pads of all four banks.
// Assumes: Pads are plain push-pull; no pull resistors.
// Notes:   A released pad shows the board level, never the last drive.
`timescale 1ns/10ps
`default_nettype none
module ppac_board (
    input wire logic [ppac_pkg::NUM_BANKS-1:0][ppac_pkg::PORT_W-1:0] pin_out,
    input wire logic [ppac_pkg::NUM_BANKS-1:0][ppac_pkg::PORT_W-1:0] pin_oe_n,
    input wire logic [ppac_pkg::NUM_BANKS-1:0][ppac_pkg::PORT_W-1:0] ext_level,
    output logic [ppac_pkg::NUM_BANKS-1:0][ppac_pkg::PORT_W-1:0] pin_in
);
    import ppac_pkg::*;
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule
`default_nettype wire

// [test_port_pins_analog_config.sv]
// Purpose: Self-checking bench for the parallel port block.
// Assumes: Avalon-MM master, one request at a time.
// Notes:   Reads are checked by a monitor against a queue of expectations.
`timescale 1ns/10ps
`default_nettype none
module test_port_pins_analog_config;
    import ppac_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b0;
    logic [ADDR_W-1:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [BUS_W-1:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [BUS_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [NUM_BANKS-1:0][PORT_W-1:0] pin_in, pin_out, pin_oe_n;
    logic [NUM_BANKS-1:0][PORT_W-1:0] ext_level = '0;
    logic [PORT_W-1:0] analog_pin_select = 16'h0000;
    logic [PORT_W-1:0] converter_connect, converter_digital_mode, converter_digital_level;
    logic [15:0] rnd = 16'h0023;
    logic [15:0] expq[$];
    int mismatches = 0;
    int num_checks = 0;
    ppac_top ppac_top_inst (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .analog_pin_select(analog_pin_select), .converter_connect(converter_connect),
        .converter_digital_mode(converter_digital_mode), .converter_digital_level(converter_digital_level));
    ppac_board ppac_board_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level), .pin_in(pin_in));
    initial forever #5 clock = ~clock;
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] ra(input int b, input int r);
        return 8'(b * 16 + r * 4);
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic fail(input string msg);
        mismatches++;
        $display("Error at %0t: %s", $time, msg);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fail($sformatf("%s got %h expected %h", what, got, exp));
        end
    endtask
    // Called just after a rising edge; holds the request until the ack edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            fail("bus timeout");
            summarize();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        expq.push_back(e);
        bus(1'b0, a, 16'h0000);
    endtask
    always @(posedge clock) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (expq.size() == 0) begin
                fail("unexpected read");
            end else begin
                chk(avs_readdata[15:0], expq.pop_front(), "read");
            end
        end
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] m, v, e, sel, d, lb;
        lb = 16'h0000;
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int b = 0; b < NUM_BANKS; b++) begin
            rd(ra(b, 0), IMPL_MASK[b]);
            rd(ra(b, 1), 16'h0000);
            rd(ra(b, 2), 16'h0000);
            chk(pin_oe_n[b], 16'hffff, "oe after reset");
        end
        $display("test reset values done");
        for (int b = 0; b < NUM_BANKS; b++) begin
            m = IMPL_MASK[b];
            rnd = lfsr(rnd);
            v = rnd;
            bus(1'b1, ra(b, 2), v);
            bus(1'b1, ra(b, 0), 16'h0000);
            repeat (8) @(posedge clock);
            chk(pin_out[b], v & m, "drive");
            chk(pin_oe_n[b], ~m, "oe");
            rd(ra(b, 2), v & m);
            rd(ra(b, 1), v & m);
            bus(1'b1, ra(b, 1), ~v);
            rd(ra(b, 2), ~v & m);
            // Bank B latch value is needed again by the analog scenario
            if (b == int'(BANK_B)) begin
                lb = ~v;
            end
            ext_level[b] <= lfsr(v);
            bus(1'b1, ra(b, 0), 16'hffff);
            repeat (8) @(posedge clock);
            rd(ra(b, 0), m);
            rd(ra(b, 1), lfsr(v) & m);
        end
        $display("test drive and sample done");
        rnd = lfsr(rnd);
        sel = rnd;
        rnd = lfsr(rnd);
        e = rnd;
        m = IMPL_MASK[0];
        ext_level[0] <= e;
        analog_pin_select <= sel;
        repeat (8) @(posedge clock);
        rd(ra(0, 1), e & m & ~sel);
        chk(converter_connect, sel & m, "connect");
        chk(converter_digital_mode, 16'h0000, "mode inputs");
        rnd = lfsr(rnd);
        d = rnd;
        bus(1'b1, ra(0, 0), d);
        repeat (8) @(posedge clock);
        v = lb;
        chk(converter_digital_mode, sel & m & ~d, "mode outputs");
        chk(converter_digital_level, sel & m & ~d & v, "level");
        rd(ra(0, 1), ((v & ~d) | (e & d)) & m & ~sel);
        $display("test analog pins done");
        rd(8'h0c, 16'h0000);
        rd(8'h40, 16'h0000);
        bus(1'b1, 8'h0c, 16'hffff);
        rd(ra(0, 0), d & m);
        rd(ra(0, 2), lb & m);
        // Low byte lane only: the high latch byte must keep its value
        avs_byteenable <= 4'h1;
        bus(1'b1, ra(0, 2), 16'hffff);
        avs_byteenable <= 4'hf;
        rd(ra(0, 2), ((lb & 16'hff00) | 16'h00ff) & m);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(ra(0, 0), IMPL_MASK[0]);
        rd(ra(0, 2), 16'h0000);
        $display("test unmapped and second reset done");
        summarize();
    end
endmodule
bind ppac_top ppac_props ppac_props_inst (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .analog_pin_select(analog_pin_select),
    .converter_connect(converter_connect), .converter_digital_mode(converter_digital_mode),
    .converter_digital_level(converter_digital_level));
`default_nettype wire
